/* common/cwseq_defines.svh */
`ifndef CWSEQ_DEFINES_SVH
`define CWSEQ_DEFINES_SVH

// Register addresses on the internal register port.
`define CWSEQ_ADDR_ENABLE_INDEX 8'h6c
`define CWSEQ_ADDR_RUN_CONTROL  8'h6f
`define CWSEQ_ADDR_PROGRESS     8'h70

// Field positions.
`define CWSEQ_BIT_CLK_ENABLE    8
`define CWSEQ_BIT_LAUNCH        8
`define CWSEQ_BIT_CANCEL        9
`define CWSEQ_BIT_BUSY          0
`define CWSEQ_IDX_LSB           4
`define CWSEQ_BIT_LAST          14
`define CWSEQ_WAIT_LSB          8

// Step memory decode.
`define CWSEQ_RAM_LAST          6'h1f
`define CWSEQ_ROM_LAST          6'h30
`define CWSEQ_IDX_RESET         6'h00

// Step timing unit in nanoseconds and its cycle count at 20 MHz.
`define CWSEQ_UNIT_NS           62500
`define CWSEQ_CLK_NS            50
`define CWSEQ_UNIT_CYCLES       (`CWSEQ_UNIT_NS / `CWSEQ_CLK_NS)
`define CWSEQ_WAIT_BASE         8

`endif

/* common/cwseq_pkg.sv */
package cwseq_pkg;
    typedef enum logic [1:0] {CWSEQ_IDLE, CWSEQ_FETCH, CWSEQ_WRITE, CWSEQ_WAIT} cwseq_state_t;
endpackage

/* core/cwseq_tick.sv */
`timescale 1ns/1ps
`include "cwseq_defines.svh"

// Divider giving one enable pulse per step time unit while running.
module cwseq_tick
#(
    parameter int UNIT_CYCLES = `CWSEQ_UNIT_CYCLES
)
(
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic rstn,
    // Control and pulse.
    input  wire logic run,
    output logic      tick
);
    localparam int CW = $clog2(UNIT_CYCLES + 1);
    logic [CW-1:0] cnt_q;

    // Counts while run is high and restarts from zero when it falls.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end
        else if (!run)
        begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end
        else if (cnt_q == CW'(UNIT_CYCLES - 1))
        begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule

/* core/cwseq_run.sv */
`timescale 1ns/1ps
`include "cwseq_defines.svh"

// Summary of operation
// (RL1) Sequencer clock runs only while the enable bit 8 of first register is one.
// (RL2) Host keeps master clock running and core clock enabled while using it.
// (RL3) Host loads the six-bit first step location before launching.
// (RL4) Locations 0-31 are RAM, 32-48 ROM, 49-63 reserved.
// (RL5) Writing one to launch bit 8 starts at the first step location.
// (RL6) Each step fetches its entry, writes the field, then moves to next location.
// (RL7) Run halts after a step with last marker set, then done flag rises.
// (RL8) On finishing, the launch bit clears itself and reads back zero.
// (RL9) A programmable wait follows each step before the next executes.
// (RL10) Writing one to cancel bit 9 ends the run and returns control to host.
// (RL11) Status bit 0 reads one while running, zero when idle.
// (RL12) While running, only sequencer and reset registers may be accessed by host.
// (RL13) Status bits 9:4 show the last accessed location, kept after completion.
// (RL14) At sequence end the done flag pulses to the interrupt status register.
// (RL15) Host should prefer the built-in start-up and shutdown sequences.
// (RL16) Each step lasts 62.5 us times (2 to the wait code, plus 8).
// (RL17) Bit 14 of the second step word is the last marker.
// (RL18) Cancel clears running and launch after the current write, index kept.
module cwseq_run
    import cwseq_pkg::*;
#(
    parameter int UNIT_CYCLES = `CWSEQ_UNIT_CYCLES
)
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Host register port.
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // Step memory port.
    output logic      [5:0]  step_addr,
    output logic             step_rd,
    input  wire logic [15:0] step_word1,
    input  wire logic [15:0] step_word2,
    // Control register field write port.
    output logic             field_wr,
    output logic      [7:0]  field_reg,
    output logic      [3:0]  field_lsb,
    output logic      [2:0]  field_width,
    output logic      [7:0]  field_data,
    // Status to the rest of the control logic.
    output logic             seq_running_flag,
    output logic             seq_done_irq_flag
);
    cwseq_state_t  state_q;
    logic          seq_clock_enable_q;
    logic          seq_launch_q;
    logic          cancel_q;
    logic [5:0]    seq_first_step_location_q;
    logic [5:0]    seq_progress_location_q;
    logic [15:0]   word2_q;
    logic [16:0]   wait_q;
    logic          tick;
    logic          wr_en;
    logic          wr_run;

    // Decodes a location into a usable memory entry, reserved ones are not.
    function automatic logic loc_valid(input logic [5:0] loc);
        loc_valid = (loc <= `CWSEQ_ROM_LAST); // RL4
    endfunction

    // Step length in time units, execution included.
    function automatic logic [16:0] step_units(input logic [3:0] code);
        step_units = (17'h0_0001 << code) + 17'(`CWSEQ_WAIT_BASE); // RL16
    endfunction

    assign wr_en  = reg_wr && reg_addr == `CWSEQ_ADDR_ENABLE_INDEX;
    assign wr_run = reg_wr && reg_addr == `CWSEQ_ADDR_RUN_CONTROL;

    cwseq_tick #(.UNIT_CYCLES(UNIT_CYCLES)) u_tick
    (
        .mclk (mclk),
        .rstn (rstn),
        .run  (state_q == CWSEQ_WAIT && seq_clock_enable_q), // RL1
        .tick (tick)
    );

    // Enable bit and first step location hold host values.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            seq_clock_enable_q        <= 1'b0;
            seq_first_step_location_q <= `CWSEQ_IDX_RESET;
        end
        else
        begin
            if (wr_en)
                seq_clock_enable_q <= reg_wdata[`CWSEQ_BIT_CLK_ENABLE];
            if (wr_run)
                seq_first_step_location_q <= reg_wdata[5:0];
        end
    end

    // Cancel request is held until the current step's write has finished.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            cancel_q <= 1'b0;
        else if (wr_run && reg_wdata[`CWSEQ_BIT_CANCEL] && state_q != CWSEQ_IDLE)
            cancel_q <= 1'b1; // RL10
        else if (state_q == CWSEQ_IDLE)
            cancel_q <= 1'b0;
    end

    // Step sequencing state machine.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q                 <= CWSEQ_IDLE;
            seq_launch_q            <= 1'b0;
            seq_progress_location_q <= `CWSEQ_IDX_RESET;
            word2_q                 <= 16'h0000;
            wait_q                  <= 17'h0_0000;
            step_rd                 <= 1'b0;
            field_wr                <= 1'b0;
            field_reg               <= 8'h00;
            field_lsb               <= 4'h0;
            field_width             <= 3'h0;
            field_data              <= 8'h00;
            seq_done_irq_flag       <= 1'b0;
        end
        else
        begin
            step_rd           <= 1'b0;
            field_wr          <= 1'b0;
            seq_done_irq_flag <= 1'b0;
            unique case (state_q)
                CWSEQ_IDLE:
                begin
                    if (wr_run && reg_wdata[`CWSEQ_BIT_LAUNCH] && !reg_wdata[`CWSEQ_BIT_CANCEL]
                        && seq_clock_enable_q && loc_valid(reg_wdata[5:0]))
                    begin
                        seq_launch_q            <= 1'b1; // RL5
                        seq_progress_location_q <= reg_wdata[5:0]; // RL5
                        step_rd                 <= 1'b1;
                        state_q                 <= CWSEQ_FETCH;
                    end
                end
                CWSEQ_FETCH:
                begin
                    field_reg   <= step_word1[7:0]; // RL6
                    field_lsb   <= step_word1[11:8];
                    field_width <= step_word1[14:12];
                    field_data  <= step_word2[7:0];
                    word2_q     <= step_word2;
                    field_wr    <= 1'b1; // RL6
                    state_q     <= CWSEQ_WRITE;
                end
                CWSEQ_WRITE:
                begin
                    wait_q  <= step_units(word2_q[`CWSEQ_WAIT_LSB +: 4]) - 17'h0_0001; // RL9
                    state_q <= CWSEQ_WAIT;
                    if (cancel_q || (wr_run && reg_wdata[`CWSEQ_BIT_CANCEL]))
                    begin
                        seq_launch_q <= 1'b0; // RL18
                        state_q      <= CWSEQ_IDLE;
                    end
                end
                CWSEQ_WAIT:
                begin
                    if (cancel_q)
                    begin
                        seq_launch_q <= 1'b0; // RL18
                        state_q      <= CWSEQ_IDLE;
                    end
                    else if (tick && wait_q == 17'h0_0000)
                    begin
                        if (word2_q[`CWSEQ_BIT_LAST] || !loc_valid(seq_progress_location_q + 6'h01))
                        begin
                            seq_launch_q      <= 1'b0; // RL8
                            seq_done_irq_flag <= 1'b1; // RL7 RL14
                            state_q           <= CWSEQ_IDLE; // RL17
                        end
                        else
                        begin
                            seq_progress_location_q <= seq_progress_location_q + 6'h01; // RL6 RL13
                            step_rd                 <= 1'b1;
                            state_q                 <= CWSEQ_FETCH;
                        end
                    end
                    else if (tick)
                        wait_q <= wait_q - 17'h0_0001;
                end
            endcase
        end
    end

    assign step_addr = seq_progress_location_q;

    // Running flag and read data are registered for the outputs.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            seq_running_flag <= 1'b0;
            reg_rdata        <= 16'h0000;
        end
        else
        begin
            seq_running_flag <= (state_q != CWSEQ_IDLE); // RL11 RL12
            unique case (reg_addr)
                `CWSEQ_ADDR_ENABLE_INDEX:
                    reg_rdata <= 16'(seq_clock_enable_q) << `CWSEQ_BIT_CLK_ENABLE;
                `CWSEQ_ADDR_RUN_CONTROL:
                    reg_rdata <= (16'(seq_launch_q) << `CWSEQ_BIT_LAUNCH) | 16'(seq_first_step_location_q);
                `CWSEQ_ADDR_PROGRESS:
                    reg_rdata <= (16'(seq_progress_location_q) << `CWSEQ_IDX_LSB)
                               | 16'(state_q != CWSEQ_IDLE); // RL11 RL13
                default:
                    reg_rdata <= 16'h0000;
            endcase
        end
    end

    a_done_idle: assert property (@(posedge mclk) disable iff (!rstn) // RL7
        seq_done_irq_flag |-> state_q == CWSEQ_IDLE && !seq_launch_q)
        else $error("done flag without idle");
    a_write_after_fetch: assert property (@(posedge mclk) disable iff (!rstn) // RL6
        step_rd |=> field_wr)
        else $error("fetch not followed by write");
    a_busy_follows: assert property (@(posedge mclk) disable iff (!rstn) // RL11
        (state_q != CWSEQ_IDLE) |=> seq_running_flag)
        else $error("busy flag missing");
    a_cancel_ends: assert property (@(posedge mclk) disable iff (!rstn) // RL10
        (cancel_q && state_q == CWSEQ_WAIT) |=> state_q == CWSEQ_IDLE)
        else $error("cancel did not end run");
    a_no_tick_off: assert property (@(posedge mclk) disable iff (!rstn) // RL1
        !seq_clock_enable_q |=> !tick)
        else $error("tick while disabled");
    // A fetch raised from the wait state must point one location further on.
    a_index_steps: assert property (@(posedge mclk) disable iff (!rstn) // RL13
        (step_rd && $past(state_q) == CWSEQ_WAIT)
        |-> seq_progress_location_q == $past(seq_progress_location_q) + 6'h01)
        else $error("index did not advance by one");
    a_valid_loc: assert property (@(posedge mclk) disable iff (!rstn) // RL4
        step_rd |-> seq_progress_location_q <= `CWSEQ_ROM_LAST)
        else $error("reserved location fetched");
    // The launch bit must already have been cleared in the cycle before busy falls.
    a_launch_clear: assert property (@(posedge mclk) disable iff (!rstn) // RL8
        $fell(seq_running_flag) |-> !$past(seq_launch_q))
        else $error("launch bit left set");
endmodule

/* bench/tb_control_write_sequencer_run.sv */
`timescale 1ns/1ps

// Bench for the sequencer run control; it drives the register port and answers step fetches.
module tb_control_write_sequencer_run;
    localparam int          unit = 2;
    localparam logic [23:0] one  = 24'h00_0001;
    localparam logic [23:0] zero = 24'h00_0000;

    logic        mclk;
    logic        rstn;
    logic        reg_wr;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic [5:0]  step_addr;
    logic        step_rd;
    logic [15:0] step_word1;
    logic [15:0] step_word2;
    logic        field_wr;
    logic [7:0]  field_reg;
    logic [3:0]  field_lsb;
    logic [2:0]  field_width;
    logic [7:0]  field_data;
    logic        seq_running_flag;
    logic        seq_done_irq_flag;
    logic [15:0] rv;
    logic [23:0] recs[$];
    int          times[$];
    int          miscompares = 0;
    int          n_compared  = 0;
    int          cyc         = 0;
    int          dones       = 0;
    int          rds         = 0;

    // First step word: target register, field position and width derived from the location.
    function automatic logic [15:0] w1(input logic [5:0] a);
        return {1'b0, a[2:0], a[3:0], 8'h20 + {2'b00, a}};
    endfunction

    // Second step word: last marker at 4 and 33, long wait at 10, data from the location.
    function automatic logic [15:0] w2(input logic [5:0] a);
        return {1'b0, (a == 6'h04) || (a == 6'h21), 2'b00, (a == 6'h0a) ? 4'h4 : {3'b000, a[0]}, 8'ha0 ^ {2'b00, a}};
    endfunction

    cwseq_run #(.UNIT_CYCLES(unit)) uut (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .step_addr(step_addr), .step_rd(step_rd),
        .step_word1(step_word1), .step_word2(step_word2), .field_wr(field_wr), .field_reg(field_reg),
        .field_lsb(field_lsb), .field_width(field_width), .field_data(field_data),
        .seq_running_flag(seq_running_flag), .seq_done_irq_flag(seq_done_irq_flag));

    // Step memory answers the current location combinationally.
    assign step_word1 = w1(step_addr);
    assign step_word2 = w2(step_addr);

    // Master clock keeps running for the whole test.
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Records every field write with its cycle and counts done pulses.
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (field_wr === 1'b1)
        begin
            recs.push_back({1'b0, field_width, field_lsb, field_reg, field_data});
            times.push_back(cyc);
        end
        if (seq_done_irq_flag === 1'b1)
            dones <= dones + 1;
        if (step_rd === 1'b1)
            rds <= rds + 1;
    end

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        repeat (2) @(posedge mclk);
        #1 rv = reg_rdata;
    endtask

    task automatic wait_idle(input int lim);
        int n;
        n = 0;
        while (seq_running_flag !== 1'b0 && n < lim)
        begin
            @(posedge mclk);
            #1 n++;
        end
        if (n >= lim)
        begin
            chk("idle within bound", zero, one);
            end_of_test();
        end
    endtask

    // Launches at a location and checks every step, the spacing, the end and the status.
    task automatic run(input logic [5:0] first, input logic [5:0] last);
        int          d0;
        int          r0;
        int          g;
        int          e;
        logic [5:0]  a;
        logic [15:0] t;
        recs.delete();
        times.delete();
        d0 = dones;
        r0 = rds;
        wr(8'h6f, {8'h01, 2'b00, first});
        rd(8'h70);
        chk("busy while running", 24'(rv[0]), one);
        wait_idle(4000);
        chk("step count", 24'(recs.size()), 24'(last - first + 6'h01));
        chk("fetch count", 24'(rds - r0), 24'(last - first + 6'h01));
        for (int i = 0; i < recs.size(); i++)
        begin
            a = first + 6'(i);
            t = w2(a);
            chk("field write", recs[i], {w1(a), t[7:0]});
            if (i > 0)
            begin
                t = w2(a - 6'h01);
                e = ((2 ** t[11:8]) + 8) * unit;
                g = times[i] - times[i - 1];
                chk("step spacing", 24'(g >= e && g <= e + 5), one);
            end
        end
        chk("done pulses", 24'(dones - d0), one);
        rd(8'h70);
        chk("status", 24'(rv), {8'h00, 6'h00, last, 4'h0});
        rd(8'h6f);
        chk("launch cleared", 24'(rv[8]), zero);
        $display("test run from %0d done", first);
    endtask

    // Main sequence; ordinary control registers are never touched while busy.
    initial
    begin
        reg_wr    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        rstn      = 1'b0;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        rd(8'h70);
        chk("status after reset", 24'(rv), zero);
        wr(8'h6f, 16'h0102);
        repeat (4) @(posedge mclk);
        #1 chk("busy when disabled", 24'(seq_running_flag), zero);
        $display("test disabled launch done");
        wr(8'h6c, 16'h0100);
        rd(8'h6c);
        chk("enable readback", 24'(rv), 24'h00_0100);
        wr(8'h6f, 16'h0131);
        repeat (4) @(posedge mclk);
        #1 chk("busy on reserved", 24'(seq_running_flag), zero);
        wr(8'h6f, 16'h0302);
        repeat (4) @(posedge mclk);
        #1 chk("busy on launch with cancel", 24'(seq_running_flag), zero);
        $display("test reserved index done");
        run(6'h02, 6'h04);
        run(6'h20, 6'h21);
        run(6'h30, 6'h30);
        recs.delete();
        wr(8'h6f, 16'h010a);
        for (int n = 0; n < 100 && recs.size() == 0; n++)
            @(posedge mclk);
        if (recs.size() == 0)
        begin
            chk("first write before cancel", zero, one);
            end_of_test();
        end
        wr(8'h6f, 16'h0200);
        wait_idle(20);
        chk("writes before cancel", 24'(recs.size()), one);
        rd(8'h70);
        chk("status after cancel", 24'(rv), 24'h00_00a0);
        rd(8'h6f);
        chk("launch after cancel", 24'(rv[8]), zero);
        $display("test cancel done");
        end_of_test();
    end
endmodule
